// >>> rtl/tlbr_top.sv
// Purpose: translation entry read-back views and config space decode
// Assumes: fill and config request ports come from logic on sys_clk
// Notes: zero-wait AHB-Lite slave; all outputs registered
`timescale 1ns/1ps
module tlbr_top (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// internal fill path from the map fetch logic
	input  wire logic        fill_valid,
	input  wire logic [2:0]  fill_idx,
	input  wire logic [29:0] fill_tag,
	input  wire logic        fill_vld,
	input  wire logic [17:0] fill_pfn,
	output logic             fill_ready,
	// processor config request and resulting cycle
	input  wire logic        cpu_cfg_req,
	input  wire logic [33:0] cpu_cfg_addr,
	output logic             cfg_cyc_go,
	output logic             cfg_cyc_rsvd,
	output logic      [31:0] cfg_cyc_addr
);
	// complete state of the block
	typedef struct packed {
		tlbr_pkg::tlbr_phase_t phase;
		logic [5:0]            waddr;
		logic [31:0]           hrdata;
		logic                  hreadyout;
		logic                  hresp;
		logic [31:0]           ctrl;
		logic [31:0]           probe;
		logic [31:0]           result;
		logic                  fill_ready;
		logic                  cfg_go;
		logic                  cfg_rsvd;
		logic [31:0]           cfg_addr;
	} tlbr_top_st_t;

	tlbr_top_st_t st_reg;      // registered state
	tlbr_top_st_t st_next;     // next state

	logic [7:0][63:0] e_view;  // live views of all entries
	logic             fill_we; // fill accepted this cycle
	logic             a_phase; // address phase taken
	logic [5:0]       a_word;  // word index of the address phase
	logic [2:0]       a_ent;   // entry addressed by a_word
	logic             a_isent; // address hits an entry view
	logic [63:0]      sel_view; // view of the addressed entry
	logic [31:0]      rd_word; // read data for the address phase
	logic             pr_hit;  // probe decode: valid target
	logic             pr_rsvd; // probe decode: reserved window
	logic [31:0]      pr_addr; // probe decode: config address
	logic             cq_hit;  // request decode: valid target
	logic             cq_rsvd; // request decode: reserved window
	logic [31:0]      cq_addr; // request decode: config address

	// fill only while software leaves the storage enabled
	assign fill_we = fill_valid && st_reg.fill_ready;

	// entry storage, one instance per entry
	genvar gi;
	generate
		for (gi = 0; gi < tlbr_pkg::ENTRY_NUM; gi++) begin : g_ent
			tlbr_entry u_ent (
				.sys_clk (sys_clk),
				.sys_rst (sys_rst),
				.wr_en   (fill_we && (fill_idx == 3'(gi))),
				.wr_tag  (fill_tag),
				.wr_vld  (fill_vld),
				.wr_pfn  (fill_pfn),
				.view    (e_view[gi])
			);
		end
	endgenerate

	// decoder for software probe address (upper bits implied)
	tlbr_cfg_decode u_probe_dec (
		.ev_addr  ({tlbr_pkg::EV_TOP[6:5], st_reg.probe}),
		.hit      (pr_hit),
		.rsvd     (pr_rsvd),
		.pci_addr (pr_addr)
	);

	// decoder for live processor config requests
	tlbr_cfg_decode u_req_dec (
		.ev_addr  (cpu_cfg_addr),
		.hit      (cq_hit),
		.rsvd     (cq_rsvd),
		.pci_addr (cq_addr)
	);

	// address phase decode
	always_comb begin
		a_phase  = hsel && hready && htrans[1];
		a_word   = haddr[7:2];
		a_isent  = (a_word < 6'(tlbr_pkg::ENTRY_WORDS));
		a_ent    = 3'(tlbr_pkg::ENTRY_FIRST) + a_word[3:1];
		sel_view = e_view[a_ent];
	end

	// read mux; unmapped words read zero
	always_comb begin
		rd_word = 32'h0000_0000;
		if (a_isent) begin
			// odd word is the upper half of the view
			rd_word = a_word[0] ? sel_view[63:32] : sel_view[31:0];
		end else begin
			case ({a_word, 2'b00})
				tlbr_pkg::OFS_CTRL: begin
					rd_word = st_reg.ctrl;
				end
				tlbr_pkg::OFS_PROBE: begin
					rd_word = st_reg.probe;
				end
				tlbr_pkg::OFS_RESULT: begin
					rd_word = st_reg.result;
				end
				default: begin
					rd_word = 32'h0000_0000;
				end
			endcase
		end
	end

	// next state: bus slave, control, config cycle launch
	always_comb begin
		st_next = st_reg;
		// never wait, never error
		st_next.hreadyout = 1'b1;
		st_next.hresp     = tlbr_pkg::HRESP_OKAY;
		// write data phase: only control and probe store
		if (st_reg.phase == tlbr_pkg::PH_WRITE) begin
			case ({st_reg.waddr, 2'b00})
				tlbr_pkg::OFS_CTRL: begin
					st_next.ctrl = {31'h0000_0000, hwdata[tlbr_pkg::CTRL_FILL_EN]};
				end
				tlbr_pkg::OFS_PROBE: begin
					st_next.probe = hwdata;
				end
				default: begin
					// entry views and result drop the data
					st_next.ctrl = st_reg.ctrl;
				end
			endcase
		end
		// address phase picks the next data phase
		case (st_reg.phase)
			tlbr_pkg::PH_IDLE, tlbr_pkg::PH_WRITE, tlbr_pkg::PH_READ: begin
				if (!hready) begin
					st_next.phase = st_reg.phase;
				end else if (a_phase && hwrite) begin
					st_next.phase = tlbr_pkg::PH_WRITE;
					st_next.waddr = a_word;
				end else if (a_phase) begin
					st_next.phase  = tlbr_pkg::PH_READ;
					st_next.hrdata = rd_word;
				end else begin
					st_next.phase = tlbr_pkg::PH_IDLE;
				end
			end
			default: begin
				st_next.phase = tlbr_pkg::PH_IDLE;
			end
		endcase
		// probe result tracks the probe register
		st_next.result = pr_addr;
		st_next.result[tlbr_pkg::RES_HIT]  = pr_hit;
		st_next.result[tlbr_pkg::RES_RSVD] = pr_rsvd;
		// fill gate follows the control bit
		st_next.fill_ready = st_next.ctrl[tlbr_pkg::CTRL_FILL_EN];
		// config cycle: one-cycle strobes per request
		st_next.cfg_go   = cpu_cfg_req && cq_hit;
		st_next.cfg_rsvd = cpu_cfg_req && cq_rsvd;
		if (cpu_cfg_req) begin
			st_next.cfg_addr = cq_addr;
		end
	end

	// state flops, synchronous reset
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_reg            <= '0;
			st_reg.phase      <= tlbr_pkg::PH_IDLE;
			st_reg.hreadyout  <= 1'b1;
			st_reg.ctrl       <= tlbr_pkg::CTRL_RESET;
			st_reg.probe      <= tlbr_pkg::PROBE_RESET;
			st_reg.fill_ready <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from flops
	assign hreadyout    = st_reg.hreadyout;
	assign hresp        = st_reg.hresp;
	assign hrdata       = st_reg.hrdata;
	assign fill_ready   = st_reg.fill_ready;
	assign cfg_cyc_go   = st_reg.cfg_go;
	assign cfg_cyc_rsvd = st_reg.cfg_rsvd;
	assign cfg_cyc_addr = st_reg.cfg_addr;

	// checks
	// read of a low view word returns the tag
	property p_tag;
		@(posedge sys_clk) disable iff (sys_rst)
		a_phase && !hwrite && a_isent && !a_word[0]
		|=> hrdata[tlbr_pkg::TAG_MSB:0] == $past(sel_view[tlbr_pkg::TAG_MSB:0]);
	endproperty
	a_tag: assert property (p_tag) else $error("tag read mismatch");

	// read of a high view word returns valid in bit 0
	property p_vld;
		@(posedge sys_clk) disable iff (sys_rst)
		a_phase && !hwrite && a_isent && a_word[0]
		|=> hrdata[0] == $past(sel_view[tlbr_pkg::VLD_BIT]);
	endproperty
	a_vld: assert property (p_vld) else $error("valid read mismatch");

	// frame number lands in bits 18:1 of the high word
	property p_pfn;
		@(posedge sys_clk) disable iff (sys_rst)
		a_phase && !hwrite && a_isent && a_word[0]
		|=> hrdata[18:1] == $past(sel_view[tlbr_pkg::PFN_MSB:tlbr_pkg::PFN_LSB]);
	endproperty
	a_pfn: assert property (p_pfn) else $error("frame number read mismatch");

	// a write to a view ends OKAY and leaves storage alone
	property p_nowr;
		@(posedge sys_clk) disable iff (sys_rst)
		a_phase && hwrite && a_isent && !fill_valid
		##1 !fill_valid |=> hresp == tlbr_pkg::HRESP_OKAY && hreadyout && $stable(e_view);
	endproperty
	a_nowr: assert property (p_nowr) else $error("view write changed storage");

	// network controller window
	property p_net;
		@(posedge sys_clk) disable iff (sys_rst)
		cpu_cfg_req && cpu_cfg_addr[33:16] == {tlbr_pkg::EV_TOP, tlbr_pkg::WIN_NET}
		|=> cfg_cyc_go && !cfg_cyc_rsvd && cfg_cyc_addr[31:11] == tlbr_pkg::PCI_NET[31:11]
			&& cfg_cyc_addr[10:0] == $past(cpu_cfg_addr[tlbr_pkg::OFS_LSB +: tlbr_pkg::OFS_W]);
	endproperty
	a_net: assert property (p_net) else $error("network window misrouted");

	// scsi controller window
	property p_scsi;
		@(posedge sys_clk) disable iff (sys_rst)
		cpu_cfg_req && cpu_cfg_addr[33:16] == {tlbr_pkg::EV_TOP, tlbr_pkg::WIN_SCSI}
		|=> cfg_cyc_go && cfg_cyc_addr[31:11] == tlbr_pkg::PCI_SCSI[31:11]
			&& cfg_cyc_addr[10:0] == $past(cpu_cfg_addr[tlbr_pkg::OFS_LSB +: tlbr_pkg::OFS_W]);
	endproperty
	a_scsi: assert property (p_scsi) else $error("scsi window misrouted");

	// eisa bridge window
	property p_eisa;
		@(posedge sys_clk) disable iff (sys_rst)
		cpu_cfg_req && cpu_cfg_addr[33:16] == {tlbr_pkg::EV_TOP, tlbr_pkg::WIN_EISA}
		|=> cfg_cyc_go && cfg_cyc_addr[31:11] == tlbr_pkg::PCI_EISA[31:11]
			&& cfg_cyc_addr[10:0] == $past(cpu_cfg_addr[tlbr_pkg::OFS_LSB +: tlbr_pkg::OFS_W]);
	endproperty
	a_eisa: assert property (p_eisa) else $error("eisa window misrouted");

	// slot 2 window and a reserved window
	property p_slot;
		@(posedge sys_clk) disable iff (sys_rst)
		cpu_cfg_req && cpu_cfg_addr[33:16] == {tlbr_pkg::EV_TOP, tlbr_pkg::WIN_SLOT2}
		|=> cfg_cyc_go && cfg_cyc_addr[31:11] == tlbr_pkg::PCI_SLOT2[31:11]
			&& cfg_cyc_addr[10:0] == $past(cpu_cfg_addr[tlbr_pkg::OFS_LSB +: tlbr_pkg::OFS_W]);
	endproperty
	a_slot: assert property (p_slot) else $error("slot window misrouted");

	property p_rsvd;
		@(posedge sys_clk) disable iff (sys_rst)
		cpu_cfg_req && cpu_cfg_addr[26:16] == 11'h008 && cpu_cfg_addr[33:27] == tlbr_pkg::EV_TOP
		|=> cfg_cyc_rsvd && !cfg_cyc_go;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved window launched");

	// an accepted fill shows in the view on the next cycle
	property p_fill;
		@(posedge sys_clk) disable iff (sys_rst)
		fill_valid && fill_ready && fill_idx == 3'h3
		|=> e_view[3][tlbr_pkg::TAG_MSB:0] == $past(fill_tag) && e_view[3][tlbr_pkg::VLD_BIT] == $past(fill_vld);
	endproperty
	a_fill: assert property (p_fill) else $error("fill not visible");

	// unassigned view bits read zero
	property p_zero;
		@(posedge sys_clk) disable iff (sys_rst)
		a_phase && !hwrite && a_isent
		|=> ($past(a_word[0]) ? hrdata[31:19] == 13'h0000 : hrdata[31:30] == 2'h0) [*1];
	endproperty
	a_zero: assert property (p_zero) else $error("spare bits nonzero");

	// slot 0 and slot 1 windows
	property p_slot0;
		@(posedge sys_clk) disable iff (sys_rst)
		cpu_cfg_req && cpu_cfg_addr[33:16] == {tlbr_pkg::EV_TOP, tlbr_pkg::WIN_SLOT0}
		|=> cfg_cyc_go && cfg_cyc_addr[31:11] == tlbr_pkg::PCI_SLOT0[31:11]
			&& cfg_cyc_addr[10:0] == $past(cpu_cfg_addr[tlbr_pkg::OFS_LSB +: tlbr_pkg::OFS_W]);
	endproperty
	a_slot0: assert property (p_slot0) else $error("slot 0 window misrouted");

	property p_slot1;
		@(posedge sys_clk) disable iff (sys_rst)
		cpu_cfg_req && cpu_cfg_addr[33:16] == {tlbr_pkg::EV_TOP, tlbr_pkg::WIN_SLOT1}
		|=> cfg_cyc_go && cfg_cyc_addr[31:11] == tlbr_pkg::PCI_SLOT1[31:11]
			&& cfg_cyc_addr[10:0] == $past(cpu_cfg_addr[tlbr_pkg::OFS_LSB +: tlbr_pkg::OFS_W]);
	endproperty
	a_slot1: assert property (p_slot1) else $error("slot 1 window misrouted");

	// a request outside the config base launches nothing
	property p_miss;
		@(posedge sys_clk) disable iff (sys_rst)
		cpu_cfg_req && cpu_cfg_addr[33:27] != tlbr_pkg::EV_TOP
		|=> !cfg_cyc_go && !cfg_cyc_rsvd && cfg_cyc_addr == 32'h0000_0000;
	endproperty
	a_miss: assert property (p_miss) else $error("out-of-base request launched");

	// a fill offered while the gate is shut leaves storage alone
	property p_gate;
		@(posedge sys_clk) disable iff (sys_rst)
		fill_valid && !fill_ready |=> $stable(e_view);
	endproperty
	a_gate: assert property (p_gate) else $error("gated fill reached storage");

	// the slave never stretches or errors a transfer
	property p_okay;
		@(posedge sys_clk) disable iff (sys_rst)
		hreadyout && hresp == tlbr_pkg::HRESP_OKAY;
	endproperty
	a_okay: assert property (p_okay) else $error("bus response not ready okay");

	// main scenarios
	c_rd_view: cover property (@(posedge sys_clk) disable iff (sys_rst) a_phase && !hwrite && a_isent);
	c_wr_view: cover property (@(posedge sys_clk) disable iff (sys_rst) a_phase && hwrite && a_isent);
	c_cfg_go:  cover property (@(posedge sys_clk) disable iff (sys_rst) cfg_cyc_go);
	c_fill:    cover property (@(posedge sys_clk) disable iff (sys_rst) fill_we);
endmodule : tlbr_top

// >>> shared/tlbr_pkg.sv
// Purpose: constants and types for the translation entry view and config decode
// Assumes: 32-bit AHB-Lite register bus, 34-bit processor-side addresses
// Notes: decode windows are one-hot bits above a fixed base
// Operation
// - entry view low bits show the tag
// - entry view bit 32 shows valid
// - entry view bits 50:33 show frame number
// - writes to entry views complete OKAY, change nothing
// - window 3.9001.0000 reaches network controller at 0800
// - window 3.9002.0000 reaches SCSI controller at 1000
// - window 3.9004.0000 reaches EISA bridge at 2000
// - slot windows one-hot bits, other windows reserved
// - internal fills load the entry storage
package tlbr_pkg;
	// entry view field layout (64-bit view)
	localparam int unsigned TAG_W     = 30;
	localparam int unsigned TAG_MSB   = 29;
	localparam int unsigned VLD_BIT   = 32;
	localparam int unsigned PFN_W     = 18;
	localparam int unsigned PFN_LSB   = 33;
	localparam int unsigned PFN_MSB   = 50;
	// entry numbering; storage holds all, only 3..7 are visible
	localparam int unsigned ENTRY_NUM   = 8;
	localparam int unsigned ENTRY_FIRST = 3;
	localparam int unsigned ENTRY_WORDS = 10;
	// register byte offsets
	localparam logic [7:0] OFS_ENTRY  = 8'h00;
	localparam logic [7:0] OFS_CTRL   = 8'h28;
	localparam logic [7:0] OFS_PROBE  = 8'h2c;
	localparam logic [7:0] OFS_RESULT = 8'h30;
	// control and result fields
	localparam int unsigned  CTRL_FILL_EN = 0;
	localparam logic [31:0]  CTRL_RESET   = 32'h0000_0001;
	localparam logic [31:0]  PROBE_RESET  = 32'h0000_0000;
	localparam int unsigned  RES_HIT      = 31;
	localparam int unsigned  RES_RSVD     = 30;
	// processor-side config address decode
	localparam int unsigned EV_W      = 34;
	localparam logic [6:0]  EV_TOP    = 7'h72;
	localparam int unsigned WIN_LSB   = 16;
	localparam int unsigned WIN_W     = 11;
	localparam int unsigned OFS_LSB   = 5;
	localparam int unsigned OFS_W     = 11;
	localparam int unsigned PCI_SHIFT = 11;
	localparam logic [10:0] WIN_NET   = 11'h001;
	localparam logic [10:0] WIN_SCSI  = 11'h002;
	localparam logic [10:0] WIN_EISA  = 11'h004;
	localparam logic [10:0] WIN_SLOT0 = 11'h040;
	localparam logic [10:0] WIN_SLOT1 = 11'h080;
	localparam logic [10:0] WIN_SLOT2 = 11'h100;
	localparam logic [10:0] WIN_RSVD  = 11'h638;
	// expected config addresses, used by checks
	localparam logic [31:0] PCI_NET   = 32'h0000_0800;
	localparam logic [31:0] PCI_SCSI  = 32'h0000_1000;
	localparam logic [31:0] PCI_EISA  = 32'h0000_2000;
	localparam logic [31:0] PCI_SLOT0 = 32'h0002_0000;
	localparam logic [31:0] PCI_SLOT1 = 32'h0004_0000;
	localparam logic [31:0] PCI_SLOT2 = 32'h0008_0000;
	// bus codes
	localparam logic        HRESP_OKAY = 1'b0;
	// data phase state of the bus slave
	typedef enum logic [2:0] {
		PH_IDLE  = 3'b001,
		PH_WRITE = 3'b010,
		PH_READ  = 3'b100
	} tlbr_phase_t;
endpackage : tlbr_pkg

// >>> rtl/tlbr_entry.sv
// Purpose: one translation entry with its 64-bit read-back view
// Assumes: loaded only by the internal fill path
// Notes: bus writes never reach this module
`timescale 1ns/1ps
module tlbr_entry (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        wr_en,
	input  wire logic [29:0] wr_tag,
	input  wire logic        wr_vld,
	input  wire logic [17:0] wr_pfn,
	output logic      [63:0] view
);
	// whole entry state
	typedef struct packed {
		logic [29:0] tag;
		logic        vld;
		logic [17:0] pfn;
	} tlbr_ent_t;
	tlbr_ent_t st_reg;   // stored entry
	tlbr_ent_t st_next;  // next entry

	// load on fill, else hold
	always_comb begin
		st_next = st_reg;
		if (wr_en) begin
			st_next = '{tag: wr_tag, vld: wr_vld, pfn: wr_pfn};
		end
	end

	// entry flops; reset leaves the entry invalid
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// live view, spare bits tied low
	assign view = {13'h0000, st_reg.pfn, st_reg.vld, 2'h0, st_reg.tag};
endmodule : tlbr_entry

// >>> rtl/tlbr_cfg_decode.sv
// Purpose: map a processor-side address to a primary config target
// Assumes: address bits 4:0 carry lane info and are not decoded
// Notes: purely combinational; caller registers the result
`timescale 1ns/1ps
module tlbr_cfg_decode (
	input  wire logic [33:0] ev_addr,
	output logic             hit,
	output logic             rsvd,
	output logic      [31:0] pci_addr
);
	logic [10:0] win;      // one-hot window select
	logic        in_base;  // upper bits match config space
	logic        onehot;   // exactly one window bit set

	// window and base checks
	always_comb begin
		win     = ev_addr[tlbr_pkg::WIN_LSB +: tlbr_pkg::WIN_W];
		in_base = (ev_addr[33:27] == tlbr_pkg::EV_TOP);
		onehot  = (win != 11'h000) && ((win & (win - 11'h001)) == 11'h000);
	end

	// a reserved window is seen but never turned into a cycle
	always_comb begin
		rsvd = in_base && onehot && ((win & tlbr_pkg::WIN_RSVD) != 11'h000);
		hit  = in_base && onehot && !rsvd;
	end

	// window bit moves down to the one-hot config address bit
	always_comb begin
		pci_addr = (32'(win) << tlbr_pkg::PCI_SHIFT)
			| 32'(ev_addr[tlbr_pkg::OFS_LSB +: tlbr_pkg::OFS_W]);
		if (!hit) begin
			pci_addr = 32'h0000_0000;
		end
	end
endmodule : tlbr_cfg_decode

// >>> testbench/tlbr_proc_model.sv
// Purpose: far-side model: map fetch fills and processor config requests
// Assumes: all requests launched right after a rising edge of sys_clk
// Notes: released lines show inverted data so stale values never pass
`timescale 1ns/1ps
module tlbr_proc_model (
	input  wire logic        sys_clk,
	output logic             fill_valid,
	output logic      [2:0]  fill_idx,
	output logic      [29:0] fill_tag,
	output logic             fill_vld,
	output logic      [17:0] fill_pfn,
	output logic             cpu_cfg_req,
	output logic      [33:0] cpu_cfg_addr
);
	// quiet at time zero
	initial begin
		fill_valid   = 1'b0;
		fill_idx     = 3'h0;
		fill_tag     = 30'h0;
		fill_vld     = 1'b0;
		fill_pfn     = 18'h0;
		cpu_cfg_req  = 1'b0;
		cpu_cfg_addr = 34'h0;
	end

	// one fill offered for a single cycle; refusal is the design's business
	task automatic fill(input logic [2:0] idx, input logic [29:0] tag, input logic vld, input logic [17:0] pfn);
		@(posedge sys_clk);
		fill_valid <= 1'b1;
		fill_idx   <= idx;
		fill_tag   <= tag;
		fill_vld   <= vld;
		fill_pfn   <= pfn;
		@(posedge sys_clk);
		// released: inverse of last value, not a stale copy
		fill_valid <= 1'b0;
		fill_idx   <= ~idx;
		fill_tag   <= ~tag;
		fill_vld   <= ~vld;
		fill_pfn   <= ~pfn;
	endtask : fill

	// one-cycle config request pulse
	task automatic cfg(input logic [33:0] addr);
		@(posedge sys_clk);
		cpu_cfg_req  <= 1'b1;
		cpu_cfg_addr <= addr;
		@(posedge sys_clk);
		cpu_cfg_req  <= 1'b0;
		cpu_cfg_addr <= ~addr;
	endtask : cfg
endmodule : tlbr_proc_model

// >>> testbench/tlbr_readback_and_cfg_decode_bench.sv
// Purpose: self-checking bench for entry views and config decode
// Assumes: zero-wait slave, but the master still waits on hready
// Notes: expectations come from the field layout, never from the design
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
	$display("unexpected %s expected %h seen %h", nm, exp, got); end end
module tlb_readback_and_cfg_decode_bench;
	logic        sys_clk;      // 100 mhz
	logic        sys_rst;      // sync, high
	logic        hsel;         // bus select
	logic [31:0] haddr;        // bus address
	logic [1:0]  htrans;       // transfer type
	logic        hwrite;       // write flag
	logic [2:0]  hsize;        // always word
	logic [31:0] hwdata;       // write data
	logic        hreadyout;    // also the bus hready
	logic        hresp;        // response
	logic [31:0] hrdata;       // read data
	logic        fill_valid;   // from model
	logic [2:0]  fill_idx;
	logic [29:0] fill_tag;
	logic        fill_vld;
	logic [17:0] fill_pfn;
	logic        fill_ready;
	logic        cpu_cfg_req;
	logic [33:0] cpu_cfg_addr;
	logic        cfg_cyc_go;
	logic        cfg_cyc_rsvd;
	logic [31:0] cfg_cyc_addr;
	int          fail_count;   // mismatches
	int          checks_done;  // comparisons

	// free-running clock
	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;

	tlbr_top tlbr_top_i (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .fill_valid(fill_valid), .fill_idx(fill_idx),
		.fill_tag(fill_tag), .fill_vld(fill_vld), .fill_pfn(fill_pfn), .fill_ready(fill_ready),
		.cpu_cfg_req(cpu_cfg_req), .cpu_cfg_addr(cpu_cfg_addr), .cfg_cyc_go(cfg_cyc_go),
		.cfg_cyc_rsvd(cfg_cyc_rsvd), .cfg_cyc_addr(cfg_cyc_addr)
	);

	tlbr_proc_model tlbr_proc_model_i (
		.sys_clk(sys_clk), .fill_valid(fill_valid), .fill_idx(fill_idx), .fill_tag(fill_tag),
		.fill_vld(fill_vld), .fill_pfn(fill_pfn), .cpu_cfg_req(cpu_cfg_req), .cpu_cfg_addr(cpu_cfg_addr)
	);

	// verdict and end of run, shared with the watchdog
	task automatic final_report;
		if (fail_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report

	// single word transfer; waits on hready at both phases
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge sys_clk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		hsize  <= 3'b010;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		`CHK("hresp", tlbr_pkg::HRESP_OKAY, hresp)
	endtask : ahb

	// both words of one entry view against the field layout
	task automatic chk_entry(input int n, input logic [29:0] tag, input logic vld, input logic [17:0] pfn);
		logic [31:0] rd;
		ahb(1'b0, 32'(8 * (n - 3)), 32'h0, rd);
		`CHK("tag", tag, rd[29:0])
		`CHK("low spare", 2'h0, rd[31:30])
		ahb(1'b0, 32'(8 * (n - 3) + 4), 32'h0, rd);
		`CHK("valid", vld, rd[0])
		`CHK("frame", pfn, rd[18:1])
		`CHK("high spare", 13'h0, rd[31:19])
	endtask : chk_entry

	// after reset: all views zero, fills enabled
	task automatic t_reset;
		logic [31:0] rd;
		for (int n = 3; n < 8; n++) chk_entry(n, 30'h0, 1'b0, 18'h0);
		ahb(1'b0, 32'h28, 32'h0, rd);
		`CHK("ctrl reset", tlbr_pkg::CTRL_RESET, rd)
	endtask : t_reset

	// fills reach views live; extreme patterns expose field slips
	task automatic t_fill;
		for (int n = 3; n < 8; n++) tlbr_proc_model_i.fill(3'(n), 30'h3fff_ffff - 30'(n), n[0], 18'h2_a5a5 ^ 18'(n));
		for (int n = 3; n < 8; n++) chk_entry(n, 30'h3fff_ffff - 30'(n), n[0], 18'h2_a5a5 ^ 18'(n));
	endtask : t_fill

	// writes to views are dropped silently; unmapped reads zero
	task automatic t_write;
		logic [31:0] rd;
		ahb(1'b1, 32'h00, 32'hffff_ffff, rd);
		ahb(1'b1, 32'h24, 32'h0000_0000, rd);
		chk_entry(3, 30'h3fff_fffc, 1'b1, 18'h2_a5a6);
		chk_entry(7, 30'h3fff_fff8, 1'b1, 18'h2_a5a2);
		ahb(1'b0, 32'h3c, 32'h0, rd);
		`CHK("unmapped", 32'h0, rd)
	endtask : t_write

	// probe register: software decode of a config address, result one cycle later
	task automatic t_probe;
		logic [31:0] rd;
		ahb(1'b1, 32'h2c, 32'h9002_0218, rd);
		ahb(1'b0, 32'h2c, 32'h0, rd);
		`CHK("probe", 32'h9002_0218, rd)
		ahb(1'b0, 32'h30, 32'h0, rd);
		`CHK("probe hit", 32'h8000_1010, rd)
		ahb(1'b1, 32'h2c, 32'h9010_0000, rd);
		ahb(1'b0, 32'h30, 32'h0, rd);
		`CHK("probe reserved", 32'h4000_0000, rd)
	endtask : t_probe

	// fills blocked while disabled; view must hold
	task automatic t_gate;
		logic [31:0] rd;
		ahb(1'b1, 32'h28, 32'h0, rd);
		@(posedge sys_clk);
		`CHK("fill ready off", 1'b0, fill_ready)
		tlbr_proc_model_i.fill(3'h5, 30'h0, 1'b0, 18'h0);
		chk_entry(5, 30'h3fff_fffa, 1'b1, 18'h2_a5a0);
		ahb(1'b1, 32'h28, 32'h1, rd);
		tlbr_proc_model_i.fill(3'h5, 30'h1234_5678, 1'b0, 18'h3_ffff);
		chk_entry(5, 30'h1234_5678, 1'b0, 18'h3_ffff);
	endtask : t_gate

	// every window of the config map, with an offset that must carry through
	task automatic t_cfg;
		logic [10:0] win [12] = '{tlbr_pkg::WIN_NET, tlbr_pkg::WIN_SCSI, tlbr_pkg::WIN_EISA, tlbr_pkg::WIN_SLOT0,
			tlbr_pkg::WIN_SLOT1, tlbr_pkg::WIN_SLOT2, 11'h008, 11'h010, 11'h020, 11'h200, 11'h400, 11'h003};
		logic [31:0] exp [6] = '{32'h0000_0800, 32'h0000_1000, 32'h0000_2000, 32'h0002_0000,
			32'h0004_0000, 32'h0008_0000};
		for (int i = 0; i < 12; i++) begin
			tlbr_proc_model_i.cfg({tlbr_pkg::EV_TOP, win[i], 16'h0218});
			#1;
			`CHK("cfg go", (i < 6), cfg_cyc_go)
			`CHK("cfg rsvd", (i >= 6 && i < 11), cfg_cyc_rsvd)
			`CHK("cfg addr", (i < 6) ? (exp[i] | 32'h10) : 32'h0, cfg_cyc_addr)
			@(posedge sys_clk);
			#1;
			`CHK("go pulse", 1'b0, cfg_cyc_go | cfg_cyc_rsvd)
		end
		// outside the config base: no cycle at all
		tlbr_proc_model_i.cfg({7'h71, tlbr_pkg::WIN_NET, 16'h0});
		#1;
		`CHK("base miss", 2'b00, {cfg_cyc_go, cfg_cyc_rsvd})
		`CHK("base miss addr", 32'h0, cfg_cyc_addr)
	endtask : t_cfg

	// bus idle at time zero, reset for 20 cycles, then the scenarios
	initial begin
		fail_count  = 0;
		checks_done = 0;
		sys_rst = 1'b1;
		hsel    = 1'b0;
		haddr   = 32'h0;
		htrans  = 2'b00;
		hwrite  = 1'b0;
		hsize   = 3'b010;
		hwdata  = 32'h0;
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_fill();
		t_write();
		t_gate();
		t_probe();
		t_cfg();
		final_report();
	end

	// hang guard, far beyond the few hundred cycles the scenarios need
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		final_report();
	end
endmodule : tlb_readback_and_cfg_decode_bench
